// ### rtl/lpr_ctrl.sv
// Low power mode and reset controller top
`timescale 1ns/10ps
`default_nettype none
module lpr_ctrl (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic reset_pin_n,
   input wire logic sc2_wr,
   input wire logic [7:0] sc2_wdata,
   output logic [7:0] sc2_rdata,
   input wire logic time_base_enable,
   input wire logic [2:0] time_base_clock_select,
   input wire logic [7:0] time_base_taps,
   input wire logic interrupt_master_enable,
   input wire logic time_base_interrupt_enable,
   input wire logic wdt_irq_pending,
   input wire logic wdt_reset_req,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic trap_ram_area_select,
   input wire logic [15:0] pc_start,
   output logic core_reset,
   output logic [15:0] pc_hold_addr,
   output logic [15:0] reset_vector_addr,
   output logic vector_fetch,
   output logic clear_int_state,
   output logic watchdog_enable,
   output logic periph_clock_enable,
   output logic time_base_clock_enable,
   output logic cpu_hold,
   output logic [2:0] mode,
   output logic sleep_state,
   output logic low_clock_active,
   output logic time_base_latch_set,
   output logic release_resume,
   output logic release_int_start
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic logic is_slow(input lpr_pkg::lpr_mode_t m);
      is_slow = (m == lpr_pkg::LPR_SLOW_BOTH_OSCILLATORS) ||
                (m == lpr_pkg::LPR_SLOW_LOW_OSCILLATOR_ONLY);
   endfunction : is_slow

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic rpin_s1_q;
   logic rpin_s2_q;
   logic [7:0] taps_s1_q;
   logic [7:0] taps_s2_q;
   logic tb_src_q;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rpin_s1_q <= 1'b1;
         rpin_s2_q <= 1'b1;
         taps_s1_q <= 8'h00;
         taps_s2_q <= 8'h00;
         tb_src_q <= 1'b0;
      end else begin
         rpin_s1_q <= reset_pin_n;
         rpin_s2_q <= rpin_s1_q;
         taps_s1_q <= time_base_taps;
         taps_s2_q <= taps_s1_q;
         tb_src_q <= taps_s2_q[time_base_clock_select];
      end
   end

   // Source edge comes from a free clock unrelated to entry time, so the
   // first falling edge may arrive well before a full period [R10]
   logic tb_fall;
   assign tb_fall = tb_src_q & ~taps_s2_q[time_base_clock_select];

   // ----------------------------------------
   // Malfunction reset stretcher
   // ----------------------------------------
   lpr_rst_if rif ();
   lpr_rst_stretch u_stretch (
      .clock(clock),
      .sys_rst(sys_rst),
      .rif(rif)
   );

   // ----------------------------------------
   // Mode state
   // ----------------------------------------
   lpr_pkg::lpr_mode_t state_q;
   lpr_pkg::lpr_mode_t state_d;
   lpr_pkg::lpr_mode_t prev_q;
   lpr_pkg::lpr_mode_t prev_d;
   logic [7:0] sc2_q;
   logic [7:0] sc2_d;
   logic [3:0] rcnt_q;
   logic [3:0] rcnt_d;
   logic ext_rst_q;
   logic ext_rst_d;
   logic [3:0] sync_q;
   logic [3:0] sync_d;
   logic [15:0] pc_hold_q;
   logic [15:0] pc_hold_d;
   logic vfetch_d;
   logic tb_latch_d;
   logic resume_d;
   logic int_start_d;
   logic malf_req;
   logic trap_hit;
   logic clk_bad;
   logic [7:0] w;
   logic run_mode;

   assign w = sc2_wdata & lpr_pkg::SC2_MASK;
   assign run_mode = (state_q == lpr_pkg::LPR_SINGLE_CLOCK_RUN) ||
                     (state_q == lpr_pkg::LPR_DUAL_CLOCK_RUN) ||
                     (state_q == lpr_pkg::LPR_CLOCK_SYNC) || is_slow(state_q);

   // Executing from data space means the program has run away
   assign trap_hit = fetch_valid && run_mode &&
      (in_range(fetch_addr, lpr_pkg::SPECIAL_LO, lpr_pkg::SPECIAL_HI) ||
       in_range(fetch_addr, lpr_pkg::DBUF_LO, lpr_pkg::DBUF_HI) ||
       (trap_ram_area_select &&
        in_range(fetch_addr, lpr_pkg::RAM_LO, lpr_pkg::RAM_HI))); // [R21]

   // Killing the oscillator that clocks the core would deadlock it
   assign clk_bad = sc2_wr && run_mode && (
      (sc2_q[lpr_pkg::SC2_HOE] && sc2_q[lpr_pkg::SC2_LOE] &&
       !w[lpr_pkg::SC2_HOE] && !w[lpr_pkg::SC2_LOE]) ||
      (sc2_q[lpr_pkg::SC2_HOE] && !w[lpr_pkg::SC2_HOE] &&
       !sc2_q[lpr_pkg::SC2_SCK]) ||
      (sc2_q[lpr_pkg::SC2_LOE] && !w[lpr_pkg::SC2_LOE] &&
       sc2_q[lpr_pkg::SC2_SCK])); // [R22]

   assign malf_req = trap_hit || wdt_reset_req || clk_bad; // [R16]
   assign rif.req = malf_req;

   always_comb begin
      state_d = state_q;
      prev_d = prev_q;
      sc2_d = sc2_q;
      sync_d = sync_q;
      pc_hold_d = pc_hold_q;
      vfetch_d = 1'b0;
      tb_latch_d = 1'b0;
      resume_d = 1'b0;
      int_start_d = 1'b0;

      // Pulses shorter than the minimum are ignored
      rcnt_d = 4'h0;
      ext_rst_d = 1'b0;
      if (!rpin_s2_q) begin
         rcnt_d = (rcnt_q == lpr_pkg::RST_CNT_LAST) ? rcnt_q : rcnt_q + 4'h1;
         ext_rst_d = ext_rst_q || (rcnt_q == lpr_pkg::RST_CNT_LAST); // [R19]
      end

      if (ext_rst_q || rif.busy || malf_req) begin
         // Reset pulls every mode, halted or slow, back to its start [R8]
         state_d = lpr_pkg::LPR_IN_RESET;
         prev_d = lpr_pkg::LPR_SINGLE_CLOCK_RUN;
         sc2_d = lpr_pkg::SC2_RESET;
         sync_d = 4'h0;
      end else begin
         unique case (state_q)
            lpr_pkg::LPR_IN_RESET: begin
               state_d = lpr_pkg::LPR_SINGLE_CLOCK_RUN; // [R8]
               vfetch_d = 1'b1; // [R20]
            end
            lpr_pkg::LPR_SINGLE_CLOCK_RUN, lpr_pkg::LPR_DUAL_CLOCK_RUN,
            lpr_pkg::LPR_SLOW_BOTH_OSCILLATORS,
            lpr_pkg::LPR_SLOW_LOW_OSCILLATOR_ONLY,
            lpr_pkg::LPR_CLOCK_SYNC: begin
               if (sc2_wr) begin
                  sc2_d = w;
                  if (w[lpr_pkg::SC2_SCK]) begin
                     // Oscillator order is the software's job [R12] [R13]
                     state_d = w[lpr_pkg::SC2_HOE] ?
                        lpr_pkg::LPR_SLOW_BOTH_OSCILLATORS :
                        lpr_pkg::LPR_SLOW_LOW_OSCILLATOR_ONLY;
                  end else if (is_slow(state_q)) begin
                     // Warm-up done by software before this write [R14]
                     state_d = lpr_pkg::LPR_CLOCK_SYNC; // [R15]
                     sync_d = lpr_pkg::CLK_SYNC_CYC;
                  end else if (state_q != lpr_pkg::LPR_CLOCK_SYNC) begin
                     state_d = w[lpr_pkg::SC2_LOE] ? lpr_pkg::LPR_DUAL_CLOCK_RUN :
                               lpr_pkg::LPR_SINGLE_CLOCK_RUN;
                  end
                  if (w[lpr_pkg::SC2_HALT]) begin
                     if (wdt_irq_pending) begin
                        sc2_d[lpr_pkg::SC2_HALT] = 1'b0; // [R9]
                     end else begin
                        prev_d = state_d; // [R4]
                        state_d = lpr_pkg::LPR_TIME_BASE_HALT; // [R3]
                        pc_hold_d = pc_start + lpr_pkg::PC_HOLD_AHEAD; // [R2]
                        tb_latch_d = time_base_enable; // [R5]
                     end
                  end
               end else if (state_q == lpr_pkg::LPR_CLOCK_SYNC) begin
                  if (sync_q == 4'h1) begin
                     state_d = sc2_q[lpr_pkg::SC2_LOE] ?
                        lpr_pkg::LPR_DUAL_CLOCK_RUN :
                        lpr_pkg::LPR_SINGLE_CLOCK_RUN;
                  end
                  sync_d = sync_q - 4'h1; // [R15]
               end
            end
            lpr_pkg::LPR_TIME_BASE_HALT: begin
               // Core is stopped, so writes here are not possible
               if (tb_fall) begin
                  sc2_d[lpr_pkg::SC2_HALT] = 1'b0; // [R4]
                  state_d = prev_q; // [R4]
                  if (interrupt_master_enable && time_base_interrupt_enable &&
                      time_base_enable) begin
                     int_start_d = 1'b1; // [R7]
                  end else begin
                     resume_d = 1'b1; // [R6]
                  end
               end
            end
            default: begin
               state_d = lpr_pkg::LPR_IN_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= lpr_pkg::LPR_IN_RESET;
         prev_q <= lpr_pkg::LPR_SINGLE_CLOCK_RUN;
         sc2_q <= lpr_pkg::SC2_RESET;
         rcnt_q <= 4'h0;
         ext_rst_q <= 1'b0;
         sync_q <= 4'h0;
         pc_hold_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         prev_q <= prev_d;
         sc2_q <= sc2_d;
         rcnt_q <= rcnt_d;
         ext_rst_q <= ext_rst_d;
         sync_q <= sync_d;
         pc_hold_q <= pc_hold_d;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   logic core_reset_q;
   logic vfetch_q;
   logic tb_latch_q;
   logic resume_q;
   logic int_start_q;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         core_reset_q <= 1'b1;
         vfetch_q <= 1'b0;
         tb_latch_q <= 1'b0;
         resume_q <= 1'b0;
         int_start_q <= 1'b0;
      end else begin
         core_reset_q <= (state_d == lpr_pkg::LPR_IN_RESET); // [R18]
         vfetch_q <= vfetch_d;
         tb_latch_q <= tb_latch_d;
         resume_q <= resume_d;
         int_start_q <= int_start_d;
      end
   end

   logic halted;
   assign halted = (state_q == lpr_pkg::LPR_TIME_BASE_HALT);

   assign core_reset = core_reset_q;
   assign clear_int_state = core_reset_q; // [R18]
   assign watchdog_enable = core_reset_q; // [R18]
   assign reset_vector_addr = lpr_pkg::VEC_RESET_LO; // [R20]
   assign vector_fetch = vfetch_q;
   assign sc2_rdata = sc2_q;
   assign pc_hold_addr = pc_hold_q;
   // Memory, registers, status word and port latches freeze with the core
   assign cpu_hold = halted; // [R1]
   assign periph_clock_enable = !halted && !core_reset_q; // [R1]
   assign time_base_clock_enable = 1'b1; // [R1]
   assign mode = state_q;
   assign sleep_state = halted && is_slow(prev_q);
   assign low_clock_active = is_slow(state_q) ||
                             (state_q == lpr_pkg::LPR_CLOCK_SYNC) ||
                             (halted && is_slow(prev_q)); // [R15]
   assign time_base_latch_set = tb_latch_q;
   assign release_resume = resume_q;
   assign release_int_start = int_start_q;

endmodule : lpr_ctrl
`default_nettype wire

// ### common/lpr_pkg.sv
// Constants and types for the low power mode and reset control block
//
// What the document requires
// [R1] In time-base idle or sleep, gate off all peripheral clocks except time base.
// [R2] In time-base idle or sleep, program counter holds start address plus two.
// [R3] Writing one to clock generator halt enters time-base idle or sleep.
// [R4] Release clears clock generator halt and returns to the mode used before.
// [R5] Time base enable set at entry sets the time-base interrupt latch.
// [R6] Enable product zero: source clock falling edge releases, execution resumes next.
// [R7] Enable product one: source clock falling edge releases and starts interrupt.
// [R8] Reset pin low releases idle, sleep and slow; restart in single-clock run.
// [R9] Watchdog interrupt pending just before entry: serve it, do not enter.
// [R10] Release runs off an asynchronous clock, so the stay may be shorter.
// [R11] Software stops peripherals such as timer counters before entering the state.
// [R12] Dual to slow: set clock select bit 5 first, then clear bit 7.
// [R13] High oscillator may run in slow; must be off before stop mode.
// [R14] Slow to dual: enable high oscillator, wait warm-up, then clear clock select.
// [R15] After clock select clears, keep low clock until both clocks are synchronised.
// [R16] Trap, watchdog or clock malfunction gives internal reset of at most 24 clocks.
// [R17] Malfunction reset logic uninitialised at power-up; spurious 24-clock reset possible.
// [R18] Reset loads FFFEH vector, clears interrupt enables and latches, enables watchdog.
// [R19] Reset pin low at least 3 machine cycles (12 clocks) initialises the device.
// [R20] Reset pin high ends reset; execution starts at vector in FFFEH to FFFFH.
// [R21] Fetch from special function, data buffer or selected RAM area gives trap reset.
// [R22] Clock reset on illegal oscillator enable clearing against clock select.
package lpr_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned RST_MIN_MACH = 3;
   localparam int unsigned CLK_PER_MACH = 4;
   localparam int unsigned RST_MIN_CYC = RST_MIN_MACH * CLK_PER_MACH;
   localparam logic [3:0] RST_CNT_LAST = 4'(RST_MIN_CYC - 1);
   localparam int unsigned MALF_RST_FC = 24;
   localparam logic [4:0] MALF_RST_CYC = 5'(MALF_RST_FC);
   localparam logic [3:0] CLK_SYNC_CYC = 4'h8;

   // ----------------------------------------
   // System control two layout
   // ----------------------------------------
   localparam int unsigned SC2_HOE = 7;
   localparam int unsigned SC2_LOE = 6;
   localparam int unsigned SC2_SCK = 5;
   localparam int unsigned SC2_HALT = 2;
   localparam logic [7:0] SC2_RESET = 8'h80;
   localparam logic [7:0] SC2_MASK = 8'he4;

   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam logic [15:0] VEC_RESET_LO = 16'hfffe;
   localparam logic [15:0] VEC_RESET_HI = 16'hffff;
   localparam logic [15:0] SPECIAL_LO = 16'h0000;
   localparam logic [15:0] SPECIAL_HI = 16'h003f;
   localparam logic [15:0] RAM_LO = 16'h0040;
   localparam logic [15:0] RAM_HI = 16'h083f;
   localparam logic [15:0] DBUF_LO = 16'h0f80;
   localparam logic [15:0] DBUF_HI = 16'h0fff;
   localparam logic [15:0] PC_HOLD_AHEAD = 16'h0002;

   // ----------------------------------------
   // Operating modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      LPR_SINGLE_CLOCK_RUN = 3'b000,
      LPR_DUAL_CLOCK_RUN = 3'b001,
      LPR_SLOW_BOTH_OSCILLATORS = 3'b010,
      LPR_SLOW_LOW_OSCILLATOR_ONLY = 3'b011,
      LPR_TIME_BASE_HALT = 3'b100,
      LPR_CLOCK_SYNC = 3'b101,
      LPR_IN_RESET = 3'b110
   } lpr_mode_t;

endpackage : lpr_pkg

// ### common/lpr_rst_if.sv
// Request and status link between the controller and its reset stretcher
`timescale 1ns/10ps
`default_nettype none
interface lpr_rst_if;
   logic req;
   logic busy;
   modport ctrl (output req, input busy);
   modport strc (input req, output busy);
endinterface : lpr_rst_if
`default_nettype wire

// ### rtl/lpr_rst_stretch.sv
// Malfunction reset stretcher
`timescale 1ns/10ps
`default_nettype none
module lpr_rst_stretch (
   input wire logic clock,
   input wire logic sys_rst,
   lpr_rst_if.strc rif
);

   logic [4:0] cnt_q;
   logic [4:0] cnt_d;

   // ----------------------------------------
   // Countdown
   // ----------------------------------------
   // Request cycle counts as the first one, so the pulse stays within the limit
   always_comb begin
      cnt_d = cnt_q;
      if (rif.req) begin
         cnt_d = lpr_pkg::MALF_RST_CYC - 5'h01; // [R16]
      end else if (cnt_q != 5'h00) begin
         cnt_d = cnt_q - 5'h01;
      end
   end

   // Real silicon may wake with any count; here zero, a legal case [R17]
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 5'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign rif.busy = (cnt_q != 5'h00); // [R16]

endmodule : lpr_rst_stretch
`default_nettype wire

// ### testbench/lpr_ctrl_props.sv
// Assertion checker for the low power mode and reset controller
`timescale 1ns/10ps
`default_nettype none
module lpr_ctrl_props (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic reset_pin_n,
   input wire logic sc2_wr,
   input wire logic [7:0] sc2_wdata,
   input wire logic [7:0] sc2_rdata,
   input wire logic time_base_enable,
   input wire logic interrupt_master_enable,
   input wire logic time_base_interrupt_enable,
   input wire logic wdt_irq_pending,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic [15:0] pc_start,
   input wire logic core_reset,
   input wire logic [15:0] pc_hold_addr,
   input wire logic [15:0] reset_vector_addr,
   input wire logic vector_fetch,
   input wire logic clear_int_state,
   input wire logic watchdog_enable,
   input wire logic periph_clock_enable,
   input wire logic time_base_clock_enable,
   input wire logic cpu_hold,
   input wire logic [2:0] mode,
   input wire logic time_base_latch_set,
   input wire logic release_resume,
   input wire logic release_int_start
);
   // ----------------------------------------
   // Reset pin low time
   // ----------------------------------------
   logic [4:0] low_q;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         low_q <= 5'h00;
      end else if (reset_pin_n) begin
         low_q <= 5'h00;
      end else if (low_q != 5'h1f) begin
         low_q <= low_q + 5'h01;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_gate; cpu_hold |-> !periph_clock_enable && time_base_clock_enable; endproperty
   a_gate: assert property (p_gate) else $error("clock gating wrong while halted");
   property p_pc; $rose(cpu_hold) |-> pc_hold_addr == $past(pc_start) + 16'h0002; endproperty
   a_pc: assert property (p_pc) else $error("held address wrong");
   property p_entry; sc2_wr && sc2_wdata[2] && sc2_wdata[7] && !sc2_wdata[5]
      && !wdt_irq_pending && mode == 3'h0 |=> cpu_hold; endproperty
   a_entry: assert property (p_entry) else $error("halt not entered");
   property p_wdt; sc2_wr && wdt_irq_pending |=> !cpu_hold; endproperty
   a_wdt: assert property (p_wdt) else $error("halt entered with watchdog pending");
   property p_rel; $fell(cpu_hold) |-> !sc2_rdata[2]
      && (release_resume || release_int_start || core_reset); endproperty
   a_rel: assert property (p_rel) else $error("halt bit not cleared on release");
   property p_int; release_int_start |->
      $past(interrupt_master_enable && time_base_interrupt_enable && time_base_enable);
   endproperty
   a_int: assert property (p_int) else $error("interrupt release without enables");
   property p_res; release_resume |->
      !$past(interrupt_master_enable && time_base_interrupt_enable && time_base_enable);
   endproperty
   a_res: assert property (p_res) else $error("plain release with enables set");
   property p_latch; $rose(cpu_hold) |-> time_base_latch_set == $past(time_base_enable);
   endproperty
   a_latch: assert property (p_latch) else $error("latch set pulse wrong");
   property p_trap; fetch_valid && fetch_addr <= 16'h003f && mode == 3'h0 |=> core_reset;
   endproperty
   a_trap: assert property (p_trap) else $error("no trap reset");
   property p_clk; sc2_wr && mode == 3'h0 && sc2_rdata[7] && !sc2_wdata[7] && !sc2_wdata[5]
      |=> core_reset; endproperty
   a_clk: assert property (p_clk) else $error("no clock reset");
   property p_pin; low_q == 5'h12 |-> core_reset; endproperty
   a_pin: assert property (p_pin) else $error("pin reset missing");
   property p_vec; $fell(core_reset) |-> vector_fetch && reset_vector_addr == 16'hfffe;
   endproperty
   a_vec: assert property (p_vec) else $error("vector fetch missing");
   property p_init; core_reset |-> clear_int_state && watchdog_enable
      && sc2_rdata == 8'h80 && !periph_clock_enable; endproperty
   a_init: assert property (p_init) else $error("reset side effects missing");
endmodule : lpr_ctrl_props
bind lpr_ctrl lpr_ctrl_props i_props (.*);
`default_nettype wire

// ### testbench/lpr_ctrl_tb.sv
// Self-checking testbench for the low power mode and reset controller
`timescale 1ns/10ps
`default_nettype none
module lpr_ctrl_tb;
   logic clock, sys_rst, reset_pin_n, sc2_wr, time_base_enable;
   logic interrupt_master_enable, time_base_interrupt_enable, wdt_irq_pending;
   logic wdt_reset_req, fetch_valid, trap_ram_area_select;
   logic [7:0] sc2_wdata, sc2_rdata, time_base_taps;
   logic [2:0] time_base_clock_select, mode;
   logic [15:0] fetch_addr, pc_start, pc_hold_addr, reset_vector_addr;
   logic core_reset, vector_fetch, clear_int_state, watchdog_enable, periph_clock_enable;
   logic time_base_clock_enable, cpu_hold, sleep_state, low_clock_active, time_base_latch_set;
   logic release_resume, release_int_start;
   int bad_count, tests_run, n;
   logic [7:0] wv [5] = '{8'hc0, 8'he0, 8'h60, 8'he0, 8'he4};
   logic [15:0] mv [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0002, 16'h0004};
   lpr_ctrl i_dut (.*);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : tick
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] d);
      sc2_wr = 1'b1;
      sc2_wdata = d;
      tick(1);
      sc2_wr = 1'b0;
   endtask : wr
   task results;
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   // Bounded wait: 0 for a release pulse, 1 for internal reset to end
   task wait_for(input int sel);
      n = 0;
      while (n < 40 && (sel == 0 ? (release_resume | release_int_start) !== 1'b1
                                 : core_reset !== 1'b0)) begin
         tick(1);
         n++;
      end
      if (n == 40) begin
         bad_count++;
         results();
      end
   endtask : wait_for
   task release_by(input int t);
      time_base_clock_select = 3'(t);
      time_base_taps = ~(8'h01 << t);
      wait_for(0);
   endtask : release_by
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      {sys_rst, reset_pin_n} = 2'b11;
      {sc2_wr, wdt_irq_pending, wdt_reset_req, fetch_valid, trap_ram_area_select} = '0;
      {interrupt_master_enable, time_base_interrupt_enable, time_base_enable} = '0;
      sc2_wdata = 8'h00;
      time_base_taps = 8'hff;
      time_base_clock_select = 3'h0;
      fetch_addr = 16'h0000;
      pc_start = 16'h0000;
      bad_count = 0;
      tests_run = 0;
      tick(3);
      sys_rst = 1'b0;
      tick(2);
      chk(16'({mode, sc2_rdata}), 16'h0080);
      chk(reset_vector_addr, 16'hfffe);
      // Halt and release with each enable product
      for (int k = 0; k < 3; k++) begin
         interrupt_master_enable = (k != 0);
         time_base_interrupt_enable = (k != 0);
         time_base_enable = (k != 2);
         pc_start = 16'h1230 + 16'(k);
         wr(8'h84);
         chk(16'(mode), 16'h0004);
         chk(16'({cpu_hold, periph_clock_enable, time_base_clock_enable}), 16'h0005);
         chk(16'(time_base_latch_set), 16'(k != 2));
         chk(pc_hold_addr, pc_start + 16'h0002);
         release_by(k);
         chk(16'({release_int_start, release_resume}), k == 1 ? 16'h0002 : 16'h0001);
         chk(16'({mode, sc2_rdata}), 16'h0080);
         time_base_taps = 8'hff;
         tick(3);
      end
      wdt_irq_pending = 1'b1;
      wr(8'h84);
      chk(16'({mode, sc2_rdata}), 16'h0080);
      wdt_irq_pending = 1'b0;
      // Dual, slow and sleep, then back through clock sync
      foreach (wv[i]) begin
         // Idle cycle so the strobe is not dropped and raised in one step
         tick(1);
         wr(wv[i]);
         chk(16'(mode), mv[i]);
      end
      chk(16'({sleep_state, cpu_hold}), 16'h0003);
      release_by(3);
      chk(16'(mode), 16'h0002);
      time_base_taps = 8'hff;
      wr(8'hc0);
      tick(4);
      chk(16'({low_clock_active, mode}), 16'h000d);
      tick(6);
      chk(16'(mode), 16'h0001);
      // Pin reset: too short, then long enough, out of slow
      wr(8'he0);
      reset_pin_n = 1'b0;
      tick(6);
      reset_pin_n = 1'b1;
      tick(6);
      chk(16'({core_reset, mode}), 16'h0002);
      reset_pin_n = 1'b0;
      tick(20);
      chk(16'({core_reset, mode}), 16'h000e);
      chk(16'({clear_int_state, watchdog_enable}), 16'h0003);
      reset_pin_n = 1'b1;
      wait_for(1);
      chk(16'({vector_fetch, mode}), 16'h0008);
      chk(16'(sc2_rdata), 16'h0080);
      tick(2);
      // Malfunction resets: watchdog, trap areas, illegal oscillator clear
      for (int c = 0; c < 6; c++) begin
         trap_ram_area_select = (c == 3);
         fetch_addr = c == 1 ? 16'h0010 : c == 2 ? 16'h0f90 : 16'h0100;
         fetch_valid = (c >= 1 && c <= 4);
         wdt_reset_req = (c == 0);
         if (c == 5) begin
            wr(8'h00);
         end else begin
            tick(1);
         end
         fetch_valid = 1'b0;
         wdt_reset_req = 1'b0;
         tick(1);
         chk(16'(core_reset), 16'(c != 4));
         wait_for(1);
         chk(16'(n <= 23), 16'h0001);
         chk(16'({mode, sc2_rdata}), 16'h0080);
         tick(2);
      end
      results();
   end
endmodule : lpr_ctrl_tb
`default_nettype wire
